//--- verilog/sar_adc_conversion_control_port.sv
`timescale 1ns/1ps
module sar_adc_conversion_control_port (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_chip_select_n,
    input wire logic i_convert_start_n,
    input wire logic i_read_n,
    input wire logic i_power_down_n,
    input wire logic i_comparator,
    input wire logic i_stream_ready,
    output logic o_busy_n,
    output logic [sar_adc_pkg::RESULT_WIDTH-1:0] o_result_bus,
    output logic o_result_bus_oe,
    output logic [sar_adc_pkg::RESULT_WIDTH-1:0] o_dac_code,
    output logic o_track,
    output logic o_nap,
    output logic o_sleep,
    output logic o_stream_valid,
    output logic [sar_adc_pkg::RESULT_WIDTH-1:0] o_stream_data
);
    import sar_adc_pkg::*;

    logic rst_meta;
    logic rst_n;
    conv_state_type state;
    conv_state_type next_state;
    power_mode_type power_mode;
    logic start_prev;
    logic power_prev;
    logic [RESULT_WIDTH-1:0] approx_register;
    logic [RESULT_WIDTH-1:0] next_approx;
    logic [RESULT_WIDTH-1:0] result_latch;
    logic [RESULT_WIDTH-1:0] dac_code;
    logic [RESULT_WIDTH-1:0] next_dac;
    logic [BIT_IDX_WIDTH-1:0] bit_idx;
    logic [STEP_CNT_WIDTH-1:0] step_cnt;
    logic [CONV_CNT_WIDTH-1:0] conv_cnt;
    logic buf_in_ready;

    // reset release through two flip-flops
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // edge detection and qualifiers
    wire start_fall = start_prev && !i_convert_start_n;
    wire start_req = start_fall && !i_chip_select_n;
    wire running = (power_mode == PM_RUN);
    wire accept = (state == ST_IDLE) && running && start_req;
    wire step_done = (step_cnt == STEP_LAST);
    wire last_bit = (bit_idx == '0);
    wire decide = (state == ST_CONVERT) && step_done;
    wire finish = decide && last_bit;
    wire handoff = (state == ST_HANDOFF) && buf_in_ready;
    wire [RESULT_WIDTH-1:0] trial_bit = RESULT_WIDTH'(1) << bit_idx;
    // offset binary to two's complement: invert the sign bit
    wire [RESULT_WIDTH-1:0] twos_word = {~approx_register[RESULT_WIDTH-1],
        approx_register[RESULT_WIDTH-2:0]};
    wire power_fall = power_prev && !i_power_down_n;

    // pin outputs
    assign o_busy_n = (state == ST_IDLE);
    assign o_result_bus_oe = !i_read_n && !i_chip_select_n;
    assign o_result_bus = result_latch;
    assign o_dac_code = dac_code;
    assign o_track = (state == ST_IDLE) && running;
    assign o_nap = (power_mode == PM_NAP);
    assign o_sleep = (power_mode == PM_SLEEP);

    // next state of the conversion sequencer
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (accept) begin
                    next_state = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (finish) begin
                    next_state = ST_HANDOFF;
                end
            end
            ST_HANDOFF: begin
                if (buf_in_ready) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // bit decision and trial code for the capacitive dac
    always_comb begin
        next_approx = approx_register;
        next_dac = '0;
        if (accept) begin
            next_approx = SAR_RESET;
        end else if (decide) begin
            next_approx[bit_idx] = i_comparator;
        end
        if (state == ST_CONVERT) begin
            next_dac = approx_register | trial_bit;
        end
    end

    // sequencer registers
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            approx_register <= SAR_RESET;
            dac_code <= SAR_RESET;
        end else begin
            state <= next_state;
            approx_register <= next_approx;
            dac_code <= next_dac;
        end
    end

    // internal step timer, msb first bit index
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            step_cnt <= '0;
            bit_idx <= BIT_IDX_MSB;
        end else if (accept) begin
            step_cnt <= '0;
            bit_idx <= BIT_IDX_MSB;
        end else if (state == ST_CONVERT) begin
            step_cnt <= step_done ? '0 : STEP_CNT_WIDTH'(step_cnt + 1'b1);
            if (decide && !last_bit) begin
                bit_idx <= BIT_IDX_WIDTH'(bit_idx - 1'b1);
            end
        end
    end

    // output latches load when the word is handed off
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            result_latch <= LATCH_RESET;
        end else if (handoff) begin
            result_latch <= twos_word;
        end
    end

    // pin history and shutdown mode
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_prev <= 1'b1;
            power_prev <= 1'b1;
            power_mode <= PM_RUN;
        end else begin
            start_prev <= i_convert_start_n;
            power_prev <= i_power_down_n;
            if (i_power_down_n) begin
                power_mode <= PM_RUN;
            end else if (power_fall) begin
                power_mode <= i_chip_select_n ? PM_SLEEP : PM_NAP;
            end
        end
    end

    // stream copy of each result; a full buffer holds busy low
    word_buffer #(
        .WIDTH(RESULT_WIDTH),
        .DEPTH(BUFFER_DEPTH)
    ) u_word_buffer (
        .i_clk(i_sys_clk),
        .i_rst_n(rst_n),
        .i_in_valid(state == ST_HANDOFF),
        .o_in_ready(buf_in_ready),
        .i_in_data(twos_word),
        .o_out_valid(o_stream_valid),
        .i_out_ready(i_stream_ready),
        .o_out_data(o_stream_data)
    );

    // helper: cycles spent converting
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_cnt <= '0;
        end else if (accept) begin
            conv_cnt <= '0;
        end else if (state == ST_CONVERT) begin
            conv_cnt <= CONV_CNT_WIDTH'(conv_cnt + 1'b1);
        end
    end

    // rule checks, all on the system clock and the internal reset copy
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!rst_n);

    // steps of a conversion that the checks below are built from
    sequence start_taken;
        (state == ST_IDLE) && running && $fell(i_convert_start_n) && !i_chip_select_n;
    endsequence

    sequence conv_begins;
        !o_busy_n && (state == ST_CONVERT) && (bit_idx == BIT_IDX_MSB);
    endsequence

    sequence word_out;
        $rose(o_busy_n) && (o_result_bus == twos_word);
    endsequence

    chk_nap_select: assert property (
        $fell(i_power_down_n) && !i_chip_select_n |=> o_nap && !o_sleep)
        else $error("nap not selected with chip select low");

    chk_sleep_select: assert property (
        $fell(i_power_down_n) && i_chip_select_n |=> o_sleep && !o_nap)
        else $error("sleep not selected with chip select high");

    chk_bus_drive: assert property (
        o_result_bus_oe |-> !i_read_n && !i_chip_select_n && (o_result_bus == result_latch))
        else $error("result bus driven without read and select");

    chk_start_edge: assert property (
        start_taken |=> conv_begins)
        else $error("start edge did not begin conversion");

    chk_start_unselected: assert property (
        o_busy_n && $fell(i_convert_start_n) && i_chip_select_n |=> o_busy_n)
        else $error("start taken without chip select");

    chk_busy_span: assert property (
        $fell(o_busy_n) |-> (!o_busy_n)[*8])
        else $error("busy rose too early");

    chk_data_ready: assert property (
        $rose(o_busy_n) |-> $past(state == ST_HANDOFF && buf_in_ready))
        else $error("busy rose without result handoff");

    chk_sar_cleared: assert property (
        start_taken |=> approx_register == SAR_RESET)
        else $error("approx register not cleared at start");

    chk_no_restart: assert property (
        (state == ST_CONVERT) && (bit_idx != BIT_IDX_MSB) |=> (state != ST_CONVERT) || (bit_idx != BIT_IDX_MSB))
        else $error("running conversion restarted");

    chk_msb_first: assert property (
        decide && !last_bit |=> bit_idx == $past(bit_idx) - 1'b1)
        else $error("bit order not msb first");

    chk_latch_load: assert property (
        handoff |=> word_out)
        else $error("output latch not loaded at conversion end");

    chk_bus_stable: assert property (
        o_busy_n && $past(o_busy_n) && !$rose(o_busy_n) |-> $stable(o_result_bus))
        else $error("result bus changed while idle");

    chk_conv_length: assert property (
        finish |-> conv_cnt == CONV_CNT_LAST)
        else $error("conversion length wrong");

    chk_twos_sign: assert property (
        handoff |=> o_result_bus[RESULT_WIDTH-1] == !$past(approx_register[RESULT_WIDTH-1]))
        else $error("sign bit not two's complement");

    chk_first_trial: assert property (
        start_taken |=> ##1 (o_dac_code == (RESULT_WIDTH'(1) << (RESULT_WIDTH - 1))))
        else $error("first trial code is not the msb alone");

    chk_dac_idle: assert property (
        (state == ST_IDLE) |=> (o_dac_code == SAR_RESET))
        else $error("trial code not cleared outside conversion");

    chk_handoff_time: assert property (
        start_taken |=> ##42 (state == ST_HANDOFF))
        else $error("conversion did not finish on time");

    chk_track_idle: assert property (
        !o_busy_n |-> !o_track)
        else $error("tracking while a conversion runs");

    chk_shutdown_hold: assert property (
        (o_nap || o_sleep) && o_busy_n |=> o_busy_n)
        else $error("conversion started in shutdown");

    chk_wake_up: assert property (
        i_power_down_n |=> !o_nap && !o_sleep)
        else $error("shutdown kept with power down high");

    chk_full_stall: assert property (
        (state == ST_HANDOFF) && !buf_in_ready |=> !o_busy_n)
        else $error("busy rose before the word was taken");

    chk_bit_steps: assert property (
        decide && !last_bit |=> (!decide)[*2] ##1 decide)
        else $error("bit decisions not evenly spaced");

    chk_bus_quiet: assert property (
        (i_read_n || i_chip_select_n) |-> !o_result_bus_oe)
        else $error("result bus driven while not read");
endmodule // sar_adc_conversion_control_port

//--- verilog/sar_adc_pkg.sv
// Behaviour
// - power_down_n low shuts down; chip select low gives nap, high gives sleep
// - result bus driven only while read strobe and chip select are both low
// - a falling edge on convert_start_n begins a new conversion
// - start and read are ignored unless chip select is low
// - busy output low throughout a conversion and while its word waits for buffer space, high otherwise
// - result is valid by the rising edge of busy; host reads after it
// - approx_register is cleared when each conversion starts
// - a running conversion cannot be restarted by further start edges
// - bits decided one per step, most significant first, over 14 bits
// - finished word moves into the output latches at conversion end; here when the word buffer accepts it, later if the buffer is full
// - result appears on fourteen parallel three-state outputs, msb down to bit zero
// - conversion timed by an internal clock, none from the host
// - result is two's complement of positive minus negative input
package sar_adc_pkg;
    localparam int RESULT_WIDTH = 14;
    localparam int CLK_PERIOD_NS = 50;
    // longest conversion time, so the per-bit step rounds down
    localparam int CONV_TIME_NS = 2200;
    localparam int BIT_STEP_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS / RESULT_WIDTH;
    localparam int CONV_CYCLES = RESULT_WIDTH * BIT_STEP_CYCLES;
    localparam int STEP_CNT_WIDTH = 4;
    localparam int BIT_IDX_WIDTH = 4;
    localparam int CONV_CNT_WIDTH = 8;
    localparam logic [STEP_CNT_WIDTH-1:0] STEP_LAST = STEP_CNT_WIDTH'(BIT_STEP_CYCLES - 1);
    localparam logic [BIT_IDX_WIDTH-1:0] BIT_IDX_MSB = BIT_IDX_WIDTH'(RESULT_WIDTH - 1);
    localparam logic [CONV_CNT_WIDTH-1:0] CONV_CNT_LAST = CONV_CNT_WIDTH'(CONV_CYCLES - 1);
    // reset values
    localparam logic [RESULT_WIDTH-1:0] SAR_RESET = 14'h0000;
    localparam logic [RESULT_WIDTH-1:0] LATCH_RESET = 14'h0000;
    localparam int BUFFER_DEPTH = 2;

    typedef enum {ST_IDLE, ST_CONVERT, ST_HANDOFF} conv_state_type;
    typedef enum {PM_RUN, PM_NAP, PM_SLEEP} power_mode_type;
endpackage

//--- verilog/word_buffer.sv
`timescale 1ns/1ps
module word_buffer #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 2
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    wire push;
    wire pop;

    // honest full and empty from the occupancy count
    assign o_in_ready = (count != CNT_FULL);
    assign o_out_valid = (count != '0);
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = mem[rd_ptr];

    // storage, written only on an accepted push
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    // pointers and count
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : PTR_W'(wr_ptr + 1'b1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : PTR_W'(rd_ptr + 1'b1);
            end
            if (push && !pop) begin
                count <= CNT_W'(count + 1'b1);
            end else if (pop && !push) begin
                count <= CNT_W'(count - 1'b1);
            end
        end
    end
endmodule // word_buffer

//--- dv/adc_far_side.sv
`timescale 1ns/1ps
// host side: comparator against a held level, stream sink that can stall
module adc_far_side (
    input wire logic i_clk,
    input wire logic i_stall,
    input wire logic [sar_adc_pkg::RESULT_WIDTH-1:0] i_level,
    input wire logic [sar_adc_pkg::RESULT_WIDTH-1:0] i_dac_code,
    input wire logic i_stream_valid,
    input wire logic [sar_adc_pkg::RESULT_WIDTH-1:0] i_stream_data,
    output logic o_comparator,
    output logic o_stream_ready,
    output logic [sar_adc_pkg::RESULT_WIDTH-1:0] o_last_word,
    output logic [7:0] o_word_count
);
    import sar_adc_pkg::*;

    logic [7:0] word_count = 8'h00;

    // keep a trial bit while the held level is at or above it
    assign o_comparator = (i_level >= i_dac_code);
    assign o_stream_ready = !i_stall;
    assign o_word_count = word_count;
    // take a word only when the handshake completes
    always @(posedge i_clk) begin
        if (i_stream_valid && o_stream_ready) begin
            o_last_word <= i_stream_data;
            word_count <= word_count + 8'h01;
        end
    end
endmodule // adc_far_side

//--- dv/tb_sar_adc_conversion_control_port.sv
`timescale 1ns/1ps
module tb_sar_adc_conversion_control_port;
    import sar_adc_pkg::*;
    logic clk, resetn, cs_n, cv_n, rd_n, pd_n, stall, cmp, s_ready, busy_n, oe, trk, nap, slp, s_valid;
    logic [13:0] level, bus, dac, s_data, last_word;
    logic [7:0] n_words;
    int fail_count = 0;
    int n_tests = 0;
    int cnt;
    logic [13:0] d0;

    sar_adc_conversion_control_port i_sar_adc_conversion_control_port (.i_sys_clk(clk), .i_resetn(resetn),
        .i_chip_select_n(cs_n), .i_convert_start_n(cv_n), .i_read_n(rd_n), .i_power_down_n(pd_n),
        .i_comparator(cmp), .i_stream_ready(s_ready), .o_busy_n(busy_n), .o_result_bus(bus),
        .o_result_bus_oe(oe), .o_dac_code(dac), .o_track(trk), .o_nap(nap), .o_sleep(slp),
        .o_stream_valid(s_valid), .o_stream_data(s_data));
    adc_far_side i_adc_far_side (.i_clk(clk), .i_stall(stall), .i_level(level), .i_dac_code(dac),
        .i_stream_valid(s_valid), .i_stream_data(s_data), .o_comparator(cmp), .o_stream_ready(s_ready),
        .o_last_word(last_word), .o_word_count(n_words));

    // clock, 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input logic [13:0] got, input logic [13:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // one conversion of a two's complement value; optional second start mid-way
    task automatic run_conv(input logic [13:0] v, input bit again);
        level = v ^ 14'h2000;
        @(negedge clk) cs_n = 1'b0;
        cv_n = 1'b0;
        cnt = 0;
        while (busy_n !== 1'b0 && cnt < 4) begin
            @(negedge clk) cnt++;
        end
        cnt = 0;
        while (busy_n === 1'b0 && cnt < 200) begin
            if (cnt == 1) d0 = dac;
            if (cnt == 1) cv_n = 1'b1;
            if (again && cnt == 10) cv_n = 1'b0;
            if (again && cnt == 12) cv_n = 1'b1;
            @(negedge clk) cnt++;
        end
        cv_n = 1'b1;
    endtask

    task automatic read_check(input logic [13:0] exp);
        rd_n = 1'b0;
        #5 chk(14'(oe), 14'h0001, "oe");
        chk(bus, exp, "bus");
        @(negedge clk) rd_n = 1'b1;
        #5 chk(14'(oe), 14'h0000, "oe off");
        repeat (10) @(negedge clk);
    endtask

    task automatic t_values;
        logic [13:0] tbl[5] = '{14'h3fff, 14'h0000, 14'h1fff, 14'h2000, 14'h1555};
        foreach (tbl[i]) begin
            run_conv(tbl[i], 1'b0);
            chk(14'(cnt), 14'h002b, "busy low cycles");
            chk(d0, 14'h2000, "first trial");
            read_check(tbl[i]);
            chk(last_word, tbl[i], "stream word");
        end
    endtask

    task automatic t_restart;
        run_conv(14'h2aaa, 1'b1);
        chk(14'(cnt), 14'h002b, "restart length");
        repeat (5) @(negedge clk);
        chk(14'(busy_n), 14'h0001, "no second run");
        read_check(14'h2aaa);
    endtask

    task automatic t_refuse;
        @(negedge clk) cs_n = 1'b1;
        cv_n = 1'b0;
        rd_n = 1'b0;
        #5 chk(14'(oe), 14'h0000, "oe with cs high");
        repeat (4) @(negedge clk);
        chk(14'(busy_n), 14'h0001, "start with cs high");
        cv_n = 1'b1;
        rd_n = 1'b1;
        repeat (3) @(negedge clk);
    endtask

    task automatic t_shutdown;
        @(negedge clk) cs_n = 1'b0;
        pd_n = 1'b0;
        repeat (2) @(negedge clk);
        chk(14'({nap, slp, trk}), 14'h0004, "nap mode");
        cv_n = 1'b0;
        repeat (4) @(negedge clk);
        chk(14'(busy_n), 14'h0001, "start in nap");
        cv_n = 1'b1;
        pd_n = 1'b1;
        @(negedge clk) cs_n = 1'b1;
        @(negedge clk) pd_n = 1'b0;
        repeat (2) @(negedge clk);
        chk(14'({nap, slp, trk}), 14'h0002, "sleep mode");
        pd_n = 1'b1;
        repeat (10) @(negedge clk);
        chk(14'({nap, slp, trk}), 14'h0001, "awake");
    endtask

    task automatic t_buffer;
        logic [7:0] w0;
        w0 = n_words;
        stall = 1'b1;
        run_conv(14'h0123, 1'b0);
        repeat (10) @(negedge clk);
        run_conv(14'h3210, 1'b0);
        chk(14'(cnt), 14'h002b, "second fits");
        chk(s_data, 14'h0123, "head word");
        repeat (10) @(negedge clk);
        run_conv(14'h1111, 1'b0);
        chk(14'(busy_n), 14'h0000, "held while full");
        stall = 1'b0;
        cnt = 0;
        while (busy_n !== 1'b1 && cnt < 10) @(negedge clk) cnt++;
        repeat (4) @(negedge clk);
        chk(14'(n_words - w0), 14'h0003, "drained count");
        chk(last_word, 14'h1111, "last drained");
        chk(14'(s_valid), 14'h0000, "empty");
        read_check(14'h1111);
    endtask

    // watchdog
    initial begin
        repeat (6000) @(posedge clk);
        fail_count++;
        tally_and_finish();
    end

    initial begin
        {cs_n, cv_n, rd_n, pd_n, stall, level} = {5'h1e, 14'h0000};
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        chk(14'({busy_n, s_valid, nap, slp, trk}), 14'h0011, "reset state");
        t_values();
        t_restart();
        t_refuse();
        t_shutdown();
        t_buffer();
        tally_and_finish();
    end
endmodule // tb_sar_adc_conversion_control_port
